// ===== hw/adcod_pkg.sv
package adcod_pkg;

    // ----------------------------------------------------------------
    // pipeline and word layout
    // ----------------------------------------------------------------
    localparam int          SAMPLE_W     = 16;
    localparam int          LATENCY      = 13;
    localparam int          WORD_W       = SAMPLE_W + 1;
    localparam int          OVR_BIT      = SAMPLE_W;
    localparam int          PIN_LVDS_N   = SAMPLE_W + 2;
    localparam int          PIN_CMOS_N   = SAMPLE_W + 3;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          CLK_MHZ      = 100;
    localparam int          DCS_MIN_MHZ  = 30;
    localparam int          RELOCK_NS    = 5000;
    localparam int          RELOCK_CYC   = (RELOCK_NS * CLK_MHZ) / 1000;
    localparam int          PERIOD_W     = 8;
    localparam int          RELOCK_W     = 10;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_MASK     = 8'h08;
    localparam logic [7:0]  OFS_SAMPLE   = 8'h0C;
    localparam logic [7:0]  OFS_PERIOD   = 8'h10;
    localparam int          CTRL_DRV_BIT = 0;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
    localparam int          EVT_W        = 3;
    localparam int          EVT_OVR      = 0;
    localparam int          EVT_RELOCK   = 1;
    localparam int          EVT_LOCK     = 2;
    localparam logic [2:0]  MASK_RESET   = 3'h0;

    // ----------------------------------------------------------------
    // stabilizer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DCS_OFF    = 2'b00,
        DCS_RELOCK = 2'b01,
        DCS_LOCKED = 2'b10
    } adcod_dcs_t;

endpackage

// ===== hw/adcod_pipe.sv
`timescale 1ns/100ps
module adcod_pipe #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 13
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             adv_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    // ----------------------------------------------------------------
    // shift stages, one step per sample edge
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] stage_reg [DEPTH];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_reg[i] <= '0;
            end
        end else if (adv_i) begin
            stage_reg[0] <= d_i;
            for (int i = 1; i < DEPTH; i++) begin
                stage_reg[i] <= stage_reg[i-1];
            end
        end
    end

    assign q_o = stage_reg[DEPTH-1];

endmodule

// ===== hw/adcod_top.sv
// Functional notes
// - each sample appears on the outputs exactly 13 sample-clock cycles after it was taken
// - outputs update one fixed delay after each rising sample-clock edge
// - format select high gives twos complement, low gives offset binary
// - output mode high drives LVDS pairs for data, over-range and data clock
// - output mode low drives single-ended data and over-range, differential data clock
// - output mode also selects which pins carry which signals
// - stabilizer mode low enables the duty stabilizer, high disables it
// - stabilizer idle below 30 MHz, bypassed for 5 us relock after rate change
`timescale 1ns/100ps
module adcod_top
    import adcod_pkg::*;
#(
    parameter int SW  = SAMPLE_W,
    parameter int LAT = LATENCY
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  sample_clk_i,
    input  wire logic [SW-1:0]         conv_data_i,
    input  wire logic                  conv_over_i,
    input  wire logic                  format_select_i,
    input  wire logic                  output_mode_i,
    input  wire logic                  duty_stabilizer_mode_i,
    input  wire logic                  hsel_i,
    input  wire logic [7:0]            haddr_i,
    input  wire logic [1:0]            htrans_i,
    input  wire logic                  hwrite_i,
    input  wire logic [2:0]            hsize_i,
    input  wire logic [31:0]           hwdata_i,
    input  wire logic                  hready_i,
    output logic                       hreadyout_o,
    output logic                       hresp_o,
    output logic [31:0]                hrdata_o,
    output logic                       irq_o,
    output logic [PIN_LVDS_N-1:0]      lvds_p_o,
    output logic [PIN_LVDS_N-1:0]      lvds_n_o,
    output logic                       lvds_oe_o,
    output logic [PIN_CMOS_N-1:0]      cmos_o,
    output logic                       cmos_oe_o,
    output logic [SW-1:0]              sample_bits_o,
    output logic                       over_range_o,
    output logic                       data_output_clock_o,
    output logic                       duty_cycle_stabilizer_o,
    output logic                       dcs_active_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [SW-1:0] fmt_word(input logic [SW-1:0] raw, input logic twos);
        fmt_word = twos ? {~raw[SW-1], raw[SW-2:0]} : raw;
    endfunction

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [SW+4:0] sync1_reg;
    logic [SW+4:0] sync2_reg;
    logic          sclk_d_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg  <= '0;
            sync2_reg  <= '0;
            sclk_d_reg <= 1'b0;
        end else begin
            sync1_reg  <= {sample_clk_i, duty_stabilizer_mode_i, output_mode_i,
                           format_select_i, conv_over_i, conv_data_i};
            sync2_reg  <= sync1_reg;
            sclk_d_reg <= sync2_reg[SW+4];
        end
    end

    wire logic             sclk_s    = sync2_reg[SW+4];
    wire logic             duty_stabilizer_mode  = sync2_reg[SW+3];
    wire logic             lvds_mode = sync2_reg[SW+2];
    wire logic             fmt_twos  = sync2_reg[SW+1];
    wire logic [WORD_W-1:0] in_word  = sync2_reg[WORD_W-1:0];
    wire logic             edge_s    = sclk_s & ~sclk_d_reg;

    // ----------------------------------------------------------------
    // sample pipeline
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] pipe_q;
    logic [WORD_W-1:0] out_raw_reg;
    logic [SW-1:0]     sample_reg;
    logic              over_reg;
    logic              dco_reg;

    adcod_pipe #(
        .WIDTH (WORD_W),
        .DEPTH (LAT)
    ) u_pipe (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .adv_i (edge_s),
        .d_i   (in_word),
        .q_o   (pipe_q)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_raw_reg <= '0;
            sample_reg  <= '0;
            over_reg    <= 1'b0;
        end else if (edge_s) begin
            out_raw_reg <= pipe_q;
            sample_reg  <= fmt_word(pipe_q[SW-1:0], fmt_twos);
            over_reg    <= pipe_q[OVR_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dco_reg <= 1'b0;
        end else begin
            dco_reg <= sclk_s;
        end
    end

    // ----------------------------------------------------------------
    // output drivers and pin maps
    // ----------------------------------------------------------------
    logic [31:0] ctrl_reg;
    wire  logic  drv_en = ctrl_reg[CTRL_DRV_BIT];
    wire  logic [PIN_LVDS_N-1:0] lvds_map = {dco_reg, over_reg, sample_reg};
    wire  logic [PIN_CMOS_N-1:0] cmos_map = {~dco_reg, dco_reg, over_reg, sample_reg};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lvds_p_o  <= '0;
            lvds_n_o  <= '0;
            lvds_oe_o <= 1'b0;
            cmos_o    <= '0;
            cmos_oe_o <= 1'b0;
        end else begin
            lvds_p_o  <= lvds_mode ? lvds_map : '0;
            lvds_n_o  <= lvds_mode ? ~lvds_map : '0;
            lvds_oe_o <= lvds_mode & drv_en;
            cmos_o    <= lvds_mode ? '0 : cmos_map;
            cmos_oe_o <= ~lvds_mode & drv_en;
        end
    end

    assign sample_bits_o       = sample_reg;
    assign over_range_o        = over_reg;
    assign data_output_clock_o = dco_reg;

    // ----------------------------------------------------------------
    // duty stabilizer control
    // ----------------------------------------------------------------
    logic [PERIOD_W-1:0] per_cnt_reg;
    logic [PERIOD_W-1:0] period_reg;
    logic [RELOCK_W-1:0] relock_reg;
    logic                dcs_en_reg;
    logic                dcs_act_reg;
    adcod_dcs_t          dcs_reg;
    adcod_dcs_t          dcs_next;

    wire logic [PERIOD_W-1:0] per_diff = (per_cnt_reg > period_reg) ? per_cnt_reg - period_reg
                                                                   : period_reg - per_cnt_reg;
    wire logic rate_slow   = (32'(per_cnt_reg) * DCS_MIN_MHZ) > CLK_MHZ;
    wire logic rate_change = edge_s && (per_diff > 8'h01);
    wire logic relock_done = (relock_reg == RELOCK_W'(RELOCK_CYC - 1));
    wire logic stuck_slow  = (32'(per_cnt_reg) * DCS_MIN_MHZ) > CLK_MHZ;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            per_cnt_reg <= '0;
            period_reg  <= '0;
        end else if (edge_s) begin
            per_cnt_reg <= 8'h01;
            period_reg  <= per_cnt_reg;
        end else if (per_cnt_reg != 8'hFF) begin
            per_cnt_reg <= per_cnt_reg + 8'h01;
        end
    end

    always_comb begin
        dcs_next = dcs_reg;
        unique case (dcs_reg)
            DCS_OFF: begin
                if (!duty_stabilizer_mode && edge_s && !rate_slow) begin
                    dcs_next = DCS_RELOCK;
                end
            end
            DCS_RELOCK: begin
                if (duty_stabilizer_mode || (edge_s && rate_slow) || stuck_slow) begin
                    dcs_next = DCS_OFF;
                end else if (relock_done) begin
                    dcs_next = DCS_LOCKED;
                end
            end
            DCS_LOCKED: begin
                if (duty_stabilizer_mode || (edge_s && rate_slow) || stuck_slow) begin
                    dcs_next = DCS_OFF;
                end else if (rate_change) begin
                    dcs_next = DCS_RELOCK;
                end
            end
            default: dcs_next = DCS_OFF;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dcs_reg     <= DCS_OFF;
            relock_reg  <= '0;
            dcs_en_reg  <= 1'b0;
            dcs_act_reg <= 1'b0;
        end else begin
            dcs_reg     <= dcs_next;
            relock_reg  <= (dcs_next == DCS_RELOCK && dcs_reg == DCS_RELOCK) ? relock_reg + 10'h001 : '0;
            dcs_en_reg  <= ~duty_stabilizer_mode;
            dcs_act_reg <= (dcs_next == DCS_LOCKED);
        end
    end

    assign duty_cycle_stabilizer_o = dcs_en_reg;
    assign dcs_active_o            = dcs_act_reg;

    // ----------------------------------------------------------------
    // events and interrupt
    // ----------------------------------------------------------------
    logic [EVT_W-1:0] status_reg;
    logic [EVT_W-1:0] mask_reg;
    logic             irq_reg;
    wire  logic [EVT_W-1:0] evt_set = {dcs_next == DCS_LOCKED && dcs_reg != DCS_LOCKED,
                                       dcs_next == DCS_RELOCK && dcs_reg == DCS_LOCKED,
                                       edge_s & pipe_q[OVR_BIT]};

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    logic       wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic       hrdy_reg;
    logic       hresp_reg;
    logic [31:0] hrdata_reg;

    wire logic        addr_ph = hsel_i & htrans_i[1] & hready_i;
    wire logic        wr_ctrl = wr_pend_reg && (wr_addr_reg == OFS_CTRL);
    wire logic        wr_stat = wr_pend_reg && (wr_addr_reg == OFS_STATUS);
    wire logic        wr_mask = wr_pend_reg && (wr_addr_reg == OFS_MASK);
    wire logic [EVT_W-1:0] st_clr = wr_stat ? hwdata_i[EVT_W-1:0] : '0;
    wire logic [EVT_W-1:0] st_next = (status_reg & ~st_clr) | evt_set;
    wire logic [31:0] rd_mux = (haddr_i == OFS_CTRL)   ? ctrl_reg :
                               (haddr_i == OFS_STATUS) ? {29'h0, status_reg} :
                               (haddr_i == OFS_MASK)   ? {29'h0, mask_reg} :
                               (haddr_i == OFS_SAMPLE) ? {15'h0, over_reg, sample_reg} :
                               (haddr_i == OFS_PERIOD) ? {22'h0, dcs_reg, period_reg} : 32'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            hrdata_reg  <= '0;
            hrdy_reg    <= 1'b1;
            hresp_reg   <= 1'b0;
        end else begin
            wr_pend_reg <= addr_ph & hwrite_i;
            wr_addr_reg <= haddr_i;
            hrdata_reg  <= (addr_ph && !hwrite_i) ? rd_mux : 32'h0;
            hrdy_reg    <= 1'b1;
            hresp_reg   <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg   <= CTRL_RESET;
            status_reg <= '0;
            mask_reg   <= MASK_RESET;
            irq_reg    <= 1'b0;
        end else begin
            ctrl_reg   <= wr_ctrl ? {31'h0, hwdata_i[CTRL_DRV_BIT]} : ctrl_reg;
            status_reg <= st_next;
            mask_reg   <= wr_mask ? hwdata_i[EVT_W-1:0] : mask_reg;
            irq_reg    <= |(st_next & (wr_mask ? hwdata_i[EVT_W-1:0] : mask_reg));
        end
    end

    assign hreadyout_o = hrdy_reg;
    assign hresp_o     = hresp_reg;
    assign hrdata_o    = hrdata_reg;
    assign irq_o       = irq_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [3:0]        h_cnt_reg;
    logic [WORD_W-1:0] h_word_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            h_cnt_reg  <= '0;
            h_word_reg <= '0;
        end else if (edge_s) begin
            if (h_cnt_reg == 4'h0) begin
                h_cnt_reg  <= 4'h1;
                h_word_reg <= in_word;
            end else if (h_cnt_reg == 4'(LAT)) begin
                h_cnt_reg <= 4'h0;
            end else begin
                h_cnt_reg <= h_cnt_reg + 4'h1;
            end
        end
    end

    a_latency_thirteen: assert property (edge_s && h_cnt_reg == 4'(LAT) |=> out_raw_reg == h_word_reg)
        else $error("sample word not out after 13 sample clocks");
    a_update_on_edge: assert property (!edge_s |=> $stable(sample_bits_o) && $stable(over_range_o))
        else $error("output data changed without sample edge");
    a_format_coding: assert property (edge_s |=> sample_bits_o ==
                                      (out_raw_reg[SW-1:0] ^ {$past(fmt_twos), {(SW-1){1'b0}}}))
        else $error("output coding does not follow format select");
    a_lvds_pairs: assert property (lvds_mode ##1 lvds_mode |=> lvds_n_o == ~lvds_p_o && cmos_o == '0)
        else $error("lvds pairs not complementary");
    a_cmos_clock_pair: assert property (!lvds_mode |=> cmos_o[PIN_CMOS_N-1] == ~cmos_o[PIN_CMOS_N-2]
                                        && lvds_p_o == '0)
        else $error("cmos clock pair not differential");
    a_pinout_exclusive: assert property (1'b1 |=> !(lvds_oe_o && cmos_oe_o)
                                         && lvds_oe_o == ($past(lvds_mode) && $past(drv_en)))
        else $error("pin set does not follow output mode");
    a_dcs_enable: assert property ($changed(duty_stabilizer_mode) |=> duty_cycle_stabilizer_o == !$past(duty_stabilizer_mode))
        else $error("stabilizer enable wrong polarity");
    a_dcs_relock: assert property (dcs_reg == DCS_LOCKED && dcs_next == DCS_RELOCK |=> !dcs_active_o [*8])
        else $error("stabilizer active during relock");
    a_dcs_slow: assert property (dcs_active_o |-> (32'(period_reg) * DCS_MIN_MHZ) <= CLK_MHZ && !$past(duty_stabilizer_mode))
        else $error("stabilizer active below minimum rate");
    a_over_aligned: assert property (edge_s && h_cnt_reg == 4'(LAT) |=> over_range_o == h_word_reg[OVR_BIT])
        else $error("over-range flag misaligned");

    c_sample_out:  cover property (edge_s && h_cnt_reg == 4'(LAT));
    c_over_range:  cover property (edge_s && pipe_q[OVR_BIT]);
    c_dcs_locked:  cover property (dcs_active_o);
    c_irq_raised:  cover property ($rose(irq_o));

endmodule

// ===== bench/adcod_capture.sv
`timescale 1ns/100ps
module adcod_capture
    import adcod_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  dclk_i,
    input  wire logic [SAMPLE_W-1:0]   bits_i,
    input  wire logic                  over_i,
    input  wire logic [PIN_LVDS_N-1:0] lvds_p_i,
    input  wire logic [PIN_LVDS_N-1:0] lvds_n_i,
    input  wire logic                  lvds_oe_i,
    output logic      [WORD_W-1:0]     word_o,
    output int                         cnt_o,
    output int                         pair_err_o
);
    // ----------------------------------------------------------------
    // capture on the falling data clock, half a period after the update
    // ----------------------------------------------------------------
    logic dclk_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dclk_q     <= 1'b0;
            word_o     <= '0;
            cnt_o      <= 0;
            pair_err_o <= 0;
        end else begin
            dclk_q <= dclk_i;
            if (dclk_q && !dclk_i) begin
                word_o <= {over_i, bits_i};
                cnt_o  <= cnt_o + 1;
            end
            if (lvds_oe_i && (lvds_n_i !== ~lvds_p_i)) begin
                pair_err_o <= pair_err_o + 1;
            end
        end
    end
endmodule

// ===== bench/testbench.sv
`timescale 1ns/100ps
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (act), (exp)); end end
module testbench
    import adcod_pkg::*;
;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic                  clk_i = 1'b0;
    logic                  rst_i = 1'b1;
    logic                  sample_clk_i = 1'b0;
    logic [SAMPLE_W-1:0]   conv_data_i = '0;
    logic                  conv_over_i = 1'b0;
    logic                  format_select_i = 1'b0;
    logic                  output_mode_i = 1'b0;
    logic                  duty_stabilizer_mode_i = 1'b0;
    logic                  hsel_i = 1'b0;
    logic [7:0]            haddr_i = 8'h00;
    logic [1:0]            htrans_i = 2'b00;
    logic                  hwrite_i = 1'b0;
    logic [2:0]            hsize_i = 3'b010;
    logic [31:0]           hwdata_i = 32'h0;
    wire logic             hready_i;
    logic                  hreadyout_o;
    logic                  hresp_o;
    logic [31:0]           hrdata_o;
    logic                  irq_o;
    logic [PIN_LVDS_N-1:0] lvds_p_o;
    logic [PIN_LVDS_N-1:0] lvds_n_o;
    logic                  lvds_oe_o;
    logic [PIN_CMOS_N-1:0] cmos_o;
    logic                  cmos_oe_o;
    logic [SAMPLE_W-1:0]   sample_bits_o;
    logic                  over_range_o;
    logic                  data_output_clock_o;
    logic                  duty_cycle_stabilizer_o;
    logic                  dcs_active_o;
    logic [WORD_W-1:0]     cap_word;
    int                    cap_cnt;
    int                    pair_err;
    logic                  sclk_run = 1'b0;
    int                    sclk_half = 40;
    int                    edge_idx = 0;
    int                    cycles = 0;
    int                    fail_count = 0;
    int                    total_checks = 0;
    logic [31:0]           rd;
    logic [WORD_W-1:0]     last_exp;

    assign hready_i = hreadyout_o;

    adcod_top uut (
        .clk_i(clk_i), .rst_i(rst_i), .sample_clk_i(sample_clk_i), .conv_data_i(conv_data_i),
        .conv_over_i(conv_over_i), .format_select_i(format_select_i), .output_mode_i(output_mode_i),
        .duty_stabilizer_mode_i(duty_stabilizer_mode_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
        .irq_o(irq_o), .lvds_p_o(lvds_p_o), .lvds_n_o(lvds_n_o), .lvds_oe_o(lvds_oe_o),
        .cmos_o(cmos_o), .cmos_oe_o(cmos_oe_o), .sample_bits_o(sample_bits_o),
        .over_range_o(over_range_o), .data_output_clock_o(data_output_clock_o),
        .duty_cycle_stabilizer_o(duty_cycle_stabilizer_o), .dcs_active_o(dcs_active_o)
    );

    adcod_capture cap (
        .clk_i(clk_i), .rst_i(rst_i), .dclk_i(data_output_clock_o), .bits_i(sample_bits_o),
        .over_i(over_range_o), .lvds_p_i(lvds_p_o), .lvds_n_i(lvds_n_o), .lvds_oe_i(lvds_oe_o),
        .word_o(cap_word), .cnt_o(cap_cnt), .pair_err_o(pair_err)
    );

    // ----------------------------------------------------------------
    // clocks and timeout
    // ----------------------------------------------------------------
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // sample clock stands still between streams; data moves on its falling edge
    initial begin
        #3;
        forever begin
            if (!sclk_run) begin
                #10;
            end else begin
                #(sclk_half) sample_clk_i = 1'b1;
                edge_idx = edge_idx + 1;
                #(sclk_half) sample_clk_i = 1'b0;
                conv_data_i = edge_idx[SAMPLE_W-1:0];
                conv_over_i = (edge_idx[1:0] == 2'b01);
            end
        end
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    function automatic logic [WORD_W-1:0] exp_word(input int n, input logic fmt);
        logic [SAMPLE_W-1:0] raw;
        raw = n[SAMPLE_W-1:0];
        return {raw[1:0] == 2'b01, raw ^ {fmt, {(SAMPLE_W-1){1'b0}}}};
    endfunction

    task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wd, output logic [31:0] rdv);
        @(posedge clk_i);
        hsel_i   <= 1'b1;
        htrans_i <= 2'b10;
        haddr_i  <= addr;
        hwrite_i <= wr;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        hsel_i   <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rdv = hrdata_o;
    endtask

    task automatic t_registers();
        ahb(1'b0, OFS_CTRL, 32'h0, rd);
        `CHK(rd, CTRL_RESET)
        ahb(1'b0, OFS_MASK, 32'h0, rd);
        `CHK(rd[EVT_W-1:0], MASK_RESET)
        ahb(1'b0, 8'h20, 32'h0, rd);
        `CHK({rd, hresp_o}, 33'h0)
        ahb(1'b1, OFS_CTRL, 32'h0, rd);
        repeat (2) @(posedge clk_i);
        `CHK({lvds_oe_o, cmos_oe_o}, 2'b00)
        ahb(1'b1, OFS_CTRL, CTRL_RESET, rd);
    endtask

    task automatic t_stream(input logic fmt, input logic mode, input int ncap);
        int prev;
        int n;
        logic [WORD_W-1:0] ew;
        @(posedge clk_i);
        format_select_i <= fmt;
        output_mode_i   <= mode;
        sclk_run        <= 1'b1;
        for (int i = 0; i < ncap + 2; i++) begin
            prev = cap_cnt;
            while (cap_cnt == prev) @(posedge clk_i);
            n = edge_idx - 2 - LATENCY; // one more pin edge has passed by now
            ew = exp_word(n, fmt);
            if (i >= 2 && n >= 0) begin
                `CHK(cap_word, ew)
                if (mode) begin
                    `CHK({lvds_n_o[WORD_W-1:0], lvds_p_o[WORD_W-1:0]}, {~ew, ew})
                    `CHK({lvds_oe_o, cmos_oe_o, cmos_o}, {2'b10, {PIN_CMOS_N{1'b0}}})
                end else begin
                    `CHK(cmos_o[WORD_W-1:0], ew)
                    `CHK(cmos_o[WORD_W+1] ^ cmos_o[WORD_W], 1'b1)
                    `CHK({lvds_oe_o, cmos_oe_o, lvds_p_o}, {2'b01, {PIN_LVDS_N{1'b0}}})
                end
            end
        end
        sclk_run <= 1'b0;
        repeat (20) @(posedge clk_i);
        last_exp = exp_word(edge_idx - 1 - LATENCY, fmt);
    endtask

    task automatic t_irq();
        ahb(1'b0, OFS_STATUS, 32'h0, rd);
        `CHK({rd[EVT_OVR], irq_o}, 2'b10)
        ahb(1'b1, OFS_MASK, 32'h1 << EVT_OVR, rd);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b1)
        ahb(1'b1, OFS_STATUS, 32'h1 << EVT_OVR, rd);
        repeat (2) @(posedge clk_i);
        ahb(1'b0, OFS_STATUS, 32'h0, rd);
        `CHK({rd[EVT_OVR], irq_o}, 2'b00)
        ahb(1'b1, OFS_SAMPLE, 32'h0, rd);
        ahb(1'b0, OFS_SAMPLE, 32'h0, rd);
        `CHK(rd[WORD_W-1:0], last_exp)
        ahb(1'b1, OFS_MASK, 32'h0, rd);
    endtask

    task automatic t_stabilizer();
        `CHK(dcs_active_o, 1'b0)
        ahb(1'b0, OFS_PERIOD, 32'h0, rd);
        `CHK(rd[9:8], DCS_OFF)
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk_i);
            duty_stabilizer_mode_i <= v[0];
            repeat (6) @(posedge clk_i);
            `CHK(duty_cycle_stabilizer_o, ~v[0])
        end
        // fast sample clock, three system cycles a period, locks the stabilizer
        sclk_half = 15;
        @(posedge clk_i);
        sclk_run <= 1'b1;
        repeat (600) @(posedge clk_i);
        `CHK(dcs_active_o, 1'b1)
        ahb(1'b0, OFS_STATUS, 32'h0, rd);
        `CHK(rd[EVT_LOCK], 1'b1)
        sclk_run <= 1'b0;
        repeat (20) @(posedge clk_i);
        `CHK(dcs_active_o, 1'b0)
        sclk_half = 40;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_registers();
        for (int i = 0; i < 4; i++) begin
            t_stream(i[0], i[1], 16);
        end
        `CHK(pair_err, 0)
        t_irq();
        t_stabilizer();
        give_verdict();
    end
endmodule
